// [core/bl1_render.sv]
// First background layer: register file, name fetch, pattern fetch, palette.
// Assumes synchronous video RAM (data one cycle after read), a pattern
// memory with req/ack handshake, and a downstream compositor on hclk.
`timescale 1ns/1ps
`include "bl1_cfg.svh"

module bl1_render (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [15:0]       vram_addr,
    output logic                   vram_rd,
    input  wire logic [15:0]       vram_rdata,
    output logic                   pat_req,
    output logic      [31:0]       pat_addr,
    input  wire logic              pat_ack,
    input  wire logic [15:0]       pat_rdata,
    output logic                   pix_valid,
    input  wire logic              pix_ready,
    output bl1_pkg::bl1_pix_t      pix
);
    localparam int NREG = 6;

    // Slot 0..5 for a register, 6 for palette, 7 for unmapped
    function automatic logic [2:0] bl1_slot(input logic [31:0] a);
        logic [15:0] i;
        i = a[17:2];
        // Upper bits must be clear so aliases never hit a register
        if (a[31:18] != 14'h0) return 3'd7;
        unique case (i)
            `BL1_IDX_SCROLL_H:   return 3'd0;
            `BL1_IDX_SCROLL_V:   return 3'd1;
            `BL1_IDX_CFG_FIRST:  return 3'd2;
            `BL1_IDX_CFG_SECOND: return 3'd3;
            `BL1_IDX_SEG_LOW:    return 3'd4;
            `BL1_IDX_SEG_HIGH:   return 3'd5;
            default: begin
                if (i[15:9] == 7'(`BL1_IDX_PAL_BASE >> 9)) return 3'd6;
                return 3'd7;
            end
        endcase
    endfunction

    // Palette address from bank and colour index per colour depth
    function automatic logic [8:0] bl1_pal_index(input logic [1:0] d,
                                                 input logic       sel,
                                                 input logic [3:0] bank,
                                                 input logic [7:0] c);
        // Fewer colour bits leave more of the bank in the address
        unique case (d)
            2'd0: return {sel, bank, 2'b00, c[1:0]};
            2'd1: return {sel, bank, c[3:0]};
            2'd2: return {sel, bank[3:2], c[5:0]};
            2'd3: return {sel, c[7:0]};
        endcase
    endfunction

    // Bus and register group
    logic [7:0]  regs      [NREG];
    logic [7:0]  next_regs [NREG];
    logic        rd_wait;
    logic        next_rd_wait;
    logic        wr_pend;
    logic        next_wr_pend;
    logic [2:0]  slot;
    logic [2:0]  next_slot;
    logic [8:0]  pal_a;
    logic [8:0]  next_pal_a;
    logic [31:0] next_hrdata;
    logic        accept;
    // No reset: software loads the palette before enabling the layer
    logic [15:0] palette [`BL1_PAL_ENTRIES];

    assign accept    = hsel & hready & htrans[1];
    // Reads take one wait state so they always see a just-written value
    assign hreadyout = ~rd_wait;
    assign hresp     = 1'b0;

    always_comb begin
        for (int k = 0; k < NREG; k++) begin
            next_regs[k] = regs[k];
        end
        next_rd_wait = 1'b0;
        next_wr_pend = 1'b0;
        next_slot    = slot;
        next_pal_a   = pal_a;
        next_hrdata  = hrdata;

        if (wr_pend && slot < 3'd6) begin
            next_regs[slot] = hwdata[7:0];
        end

        if (rd_wait) begin
            if (slot < 3'd6) begin
                next_hrdata = {24'h0, regs[slot]};
            end else if (slot == 3'd6) begin
                next_hrdata = {16'h0, palette[pal_a]};
            end else begin
                next_hrdata = 32'h0;
            end
        end

        // Address phase captured; its data phase follows
        if (accept) begin
            next_slot    = bl1_slot(haddr);
            next_pal_a   = haddr[10:2];
            next_rd_wait = ~hwrite;
            next_wr_pend = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int k = 0; k < NREG; k++) begin
                regs[k] <= `BL1_REG_RESET;
            end
            rd_wait <= 1'b0;
            wr_pend <= 1'b0;
            slot    <= 3'd7;
            pal_a   <= 9'h0;
            hrdata  <= 32'h0;
        end else begin
            for (int k = 0; k < NREG; k++) begin
                regs[k] <= next_regs[k];
            end
            rd_wait <= next_rd_wait;
            wr_pend <= next_wr_pend;
            slot    <= next_slot;
            pal_a   <= next_pal_a;
            hrdata  <= next_hrdata;
        end
    end

    // Written at the data phase edge, like the registers
    // palette storage, 512 entries
    always_ff @(posedge hclk) begin
        if (wr_pend && slot == 3'd6) begin
            palette[pal_a] <= hwdata[15:0];
        end
    end

    // Decoded configuration
    bl1_pkg::bl1_cfg1_t c1;
    logic [7:0]  c2;
    logic [15:0] seg;
    logic        hc_eff;
    logic [1:0]  cdepth;
    assign c1  = bl1_pkg::bl1_cfg1_t'(regs[2]);
    assign c2  = regs[3];
    // Segment spans both bytes, high byte on top
    assign seg = {regs[5], regs[4]};
    // high colour ignored in character mode
    assign hc_eff = c1.linear_select_bit & c1.high_colour_bit;
    assign cdepth = c1.colour_depth_field;

    // Render group
    bl1_pkg::bl1_state_t st;
    bl1_pkg::bl1_state_t next_st;
    logic [7:0]  col;
    logic [7:0]  next_col;
    logic [7:0]  row;
    logic [7:0]  next_row;
    logic [15:0] entry;
    logic [15:0] next_entry;
    logic [15:0] word;
    logic [15:0] next_word;
    logic [2:0]  sh;
    logic [2:0]  next_sh;
    logic [15:0] next_vram_addr;
    logic [31:0] next_pat_addr;
    bl1_pkg::bl1_pix_t next_pix;

    logic [8:0]  sx;
    logic [8:0]  sy;
    logic [8:0]  ex9;
    logic [8:0]  ey9;
    logic [8:0]  ex;
    logic [8:0]  ey;
    logic [11:0] idx;
    logic [7:0]  pix_in;
    logic [4:0]  bpp;
    logic [31:0] bitoff;
    logic [15:0] raw;
    logic [15:0] pal_q;

    always_comb begin
        // signed horizontal scroll, adds to screen column
        sx  = {c2[`BL1_C2_XSIGN], regs[0]};
        ex9 = {1'b0, col} + sx;
        // signed vertical scroll, adds to screen line
        sy  = {c2[`BL1_C2_YSIGN], regs[1]};
        ey9 = {1'b0, row} + sy;

        // page arrangement from both page bits
        // wrap at 256 unless the axis has two pages
        ex  = {ex9[8] & c1.horizontal_page_bit, ex9[7:0]};
        ey  = {ey9[8] & c1.vertical_page_bit, ey9[7:0]};
        if (c1.linear_select_bit) begin
            // one name entry per line of 256 pixels
            idx    = {2'b00, ey[8], ex[8], ey[7:0]};
            pix_in = ex[7:0];
        end else if (c1.character_size_bit) begin
            idx    = {2'b00, ey[8], ex[8], ey[7:4], ex[7:4]};
            pix_in = {ey[3:0], ex[3:0]};
        end else begin
            // one page bit; 8x8 cells fill half the RAM per page
            // Four pages of 8x8 would overflow the RAM, so they alias
            idx    = {1'b0, ey[8] | ex[8], ey[7:3], ex[7:3]};
            pix_in = {2'b00, ey[2:0], ex[2:0]};
        end

        bpp = hc_eff ? 5'd16 : {2'b00, cdepth, 1'b0} + 5'd2;
        // bits from entry times cell area plus pixel
        // linear mode takes 256-pixel cells whatever the size bit
        if (c1.character_size_bit || c1.linear_select_bit) begin
            bitoff = (({20'h0, vram_rdata[11:0]} << 8) + {24'h0, pix_in}) * {27'h0, bpp};
        end else begin
            bitoff = (({20'h0, vram_rdata[11:0]} << 6) + {24'h0, pix_in}) * {27'h0, bpp};
        end

        // Pixel bits start at the low end of the word
        raw   = word >> sh;
        pal_q = palette[bl1_pal_index(cdepth, c2[`BL1_C2_PALSEL], entry[15:12], raw[7:0])];
    end

    // Strobes decoded straight from the state
    assign vram_rd   = (st == bl1_pkg::S_NAME);
    assign pat_req   = (st == bl1_pkg::S_FETCH);
    assign pix_valid = (st == bl1_pkg::S_OUT);

    always_comb begin
        next_st        = st;
        next_col       = col;
        next_row       = row;
        next_entry     = entry;
        next_word      = word;
        next_sh        = sh;
        next_vram_addr = vram_addr;
        next_pat_addr  = pat_addr;
        next_pix       = pix;

        unique case (st)
            bl1_pkg::S_IDLE: begin
                // Address set here so the RAM sees it with the strobe
                // entries stay inside 0x3000-0x3FFF
                next_vram_addr = `BL1_VRAM_BASE | {4'h0, idx[10:0], 1'b0};
                next_st        = bl1_pkg::S_NAME;
            end
            bl1_pkg::S_NAME: begin
                // RAM answers one cycle after the strobe
                next_st = bl1_pkg::S_DECODE;
            end
            bl1_pkg::S_DECODE: begin
                // index in low twelve, bank in top four
                next_entry    = vram_rdata;
                next_sh       = bitoff[2:0];
                next_pat_addr = ({16'h0, seg} << `BL1_SEG_SHIFT) + (bitoff >> 3);
                next_pix.col  = col;
                next_pix.row  = row;
                next_pix.layer_depth = c2[`BL1_C2_DEPTH_LSB +: 2];
                next_pix.effect      = 1'b0;
                next_pix.rgb         = 15'h0;

                if (!c1.layer_enable_bit || vram_rdata == 16'h0) begin
                    next_pix.transparent = 1'b1;
                    next_st              = bl1_pkg::S_OUT;
                end else begin
                    next_pix.transparent = 1'b0;
                    next_st              = bl1_pkg::S_FETCH;
                end
            end
            bl1_pkg::S_FETCH: begin
                // Request held until the memory acknowledges
                // pattern fetched after name decode
                if (pat_ack) begin
                    next_word = pat_rdata;
                    next_st   = hc_eff ? bl1_pkg::S_OUT : bl1_pkg::S_PAL;
                    if (hc_eff) begin
                        // direct pixel fields taken as stored
                        // flag bit marks the pixel transparent
                        next_pix.rgb         = pat_rdata[14:0];
                        next_pix.transparent = pat_rdata[15];
                    end
                end
            end
            bl1_pkg::S_PAL: begin
                // Entry read combinationally from the palette array
                // indexed pixel translated by palette
                next_pix.rgb    = pal_q[14:0];
                next_pix.effect = pal_q[15];
                next_st         = bl1_pkg::S_OUT;
            end
            bl1_pkg::S_OUT: begin
                // A stall holds pix and freezes the raster
                // transparent pixels still emitted, flagged
                if (pix_ready) begin
                    next_st = bl1_pkg::S_IDLE;
                    next_col = col + 8'd1;
                    if (col == 8'hFF) begin
                        next_row = (row == `BL1_SCREEN_H - 8'd1) ? 8'h0 : row + 8'd1;
                    end
                end
            end
            default: next_st = bl1_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st        <= bl1_pkg::S_IDLE;
            col       <= 8'h0;
            row       <= 8'h0;
            entry     <= 16'h0;
            word      <= 16'h0;
            sh        <= 3'h0;
            vram_addr <= `BL1_VRAM_BASE;
            pat_addr  <= 32'h0;
            pix       <= '0;
        end else begin
            st        <= next_st;
            col       <= next_col;
            row       <= next_row;
            entry     <= next_entry;
            word      <= next_word;
            sh        <= next_sh;
            vram_addr <= next_vram_addr;
            pat_addr  <= next_pat_addr;
            pix       <= next_pix;
        end
    end
endmodule

// [inc/bl1_cfg.svh]
// Constants of the first background layer renderer.
// Assumes an AHB-Lite bus with 32-bit words; each register is one aligned word.
`ifndef BL1_CFG_SVH
`define BL1_CFG_SVH

// Register indices; byte address is four times the index
`define BL1_IDX_SCROLL_H   16'h2010
`define BL1_IDX_SCROLL_V   16'h2011
`define BL1_IDX_CFG_FIRST  16'h2012
`define BL1_IDX_CFG_SECOND 16'h2013
`define BL1_IDX_SEG_LOW    16'h201C
`define BL1_IDX_SEG_HIGH   16'h201D
// Palette window: entry i at index base+i
`define BL1_IDX_PAL_BASE   16'h2400
`define BL1_PAL_ENTRIES    512
`define BL1_REG_RESET      8'h00

// Second configuration register fields
`define BL1_C2_DEPTH_LSB   0
`define BL1_C2_XSIGN       2
`define BL1_C2_YSIGN       3
`define BL1_C2_PALSEL      4

`define BL1_VRAM_BASE      16'h3000
`define BL1_SEG_SHIFT      13
`define BL1_SCREEN_W       9'h100
`define BL1_SCREEN_H       8'hF0
`endif

// [inc/bl1_pkg.sv]
// Types of the first background layer renderer.
// Assumes bl1_cfg.svh supplies the numeric constants.
package bl1_pkg;
    typedef enum logic [5:0] {
        S_IDLE   = 6'b000001,
        S_NAME   = 6'b000010,
        S_DECODE = 6'b000100,
        S_FETCH  = 6'b001000,
        S_PAL    = 6'b010000,
        S_OUT    = 6'b100000
    } bl1_state_t;

    // Layout of the first configuration register, bit 7 first
    typedef struct packed {
        logic [1:0] colour_depth_field;
        logic       high_colour_bit;
        logic       character_size_bit;
        logic       linear_select_bit;
        logic       vertical_page_bit;
        logic       horizontal_page_bit;
        logic       layer_enable_bit;
    } bl1_cfg1_t;

    typedef struct packed {
        logic [7:0]  col;
        logic [7:0]  row;
        logic        transparent;
        logic        effect;
        logic [14:0] rgb;
        logic [1:0]  layer_depth;
    } bl1_pix_t;
endpackage

// [testbench/bl1_mem_model.sv]
// Video RAM and pattern memory model facing the layer renderer.
// Assumes one clock; the bench sets the name entry, pattern word and stall.
`timescale 1ns/1ps
module bl1_mem_model (
    input  wire logic        hclk,
    input  wire logic        vram_rd,
    output logic      [15:0] vram_rdata,
    input  wire logic        pat_req,
    output logic             pat_ack,
    output logic      [15:0] pat_rdata,
    input  wire logic [15:0] ent,
    input  wire logic [15:0] pat_word,
    input  wire logic        slow
);
    logic [1:0] wait_cnt;
    initial vram_rdata = 16'hFFFF;
    initial wait_cnt = 2'h0;
    // entry one cycle after read, then stale data inverted
    always @(posedge hclk) vram_rdata <= vram_rd ? ent : ~vram_rdata;
    // pattern answer, optionally three cycles late
    assign pat_ack   = pat_req && (wait_cnt == (slow ? 2'h3 : 2'h0));
    assign pat_rdata = pat_ack ? pat_word : ~pat_word;
    always @(posedge hclk) wait_cnt <= (pat_req && !pat_ack) ? wait_cnt + 2'h1 : 2'h0;
endmodule

// [testbench/bl1_render_bench.sv]
// Self-checking bench for the first background layer renderer.
// Assumes a single AHB-Lite master, the memory model and a pixel sink.
`timescale 1ns/1ps
module bl1_render_bench;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, vram_rd;
    logic              pat_req, pat_ack, pix_valid, pix_ready, slow;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [15:0]       vram_addr, vram_rdata, pat_rdata, ent, pw;
    logic [31:0]       haddr, hwdata, hrdata, pat_addr;
    wire logic         hready;
    int                bad_count, n_compared, cyc;
    bl1_pkg::bl1_pix_t pix;
    localparam logic [31:0] RA [7] = '{32'h8040, 32'h8044, 32'h8048, 32'h804C,
                                      32'h8070, 32'h8074, 32'h8050};
    localparam logic [7:0]  C1 [6] = '{8'h21, 8'h41, 8'h93, 8'hD5, 8'hD7, 8'h45};
    localparam logic [7:0]  C2 [6] = '{8'h01, 8'h16, 8'h07, 8'h08, 8'h0C, 8'h08};
    localparam logic [7:0]  SH [6] = '{8'h05, 8'hFB, 8'h10, 8'h00, 8'h81, 8'h40};
    localparam logic [7:0]  SV [6] = '{8'h03, 8'h00, 8'h07, 8'h20, 8'hC0, 8'h30};
    localparam logic [7:0]  CF [3] = '{8'hF9, 8'hF9, 8'hD9};
    localparam logic [15:0] PW [3] = '{16'h7C1F, 16'hFC1F, 16'h00A7};

    assign hready = hreadyout;
    bl1_render i_bl1_render (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .vram_addr, .vram_rd, .vram_rdata, .pat_req,
        .pat_addr, .pat_ack, .pat_rdata, .pix_valid, .pix_ready, .pix);
    bl1_mem_model i_bl1_mem_model (.hclk, .vram_rd, .vram_rdata, .pat_req, .pat_ack, .pat_rdata,
        .ent, .pat_word(pw), .slow);

    always #2.5 hclk = ~hclk;

    function automatic logic [15:0] palv(int i);
        return 16'(i * 40503) ^ 16'h5A5A;
    endfunction

    task automatic chk(string nm, logic [35:0] got, logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic ahb(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        r = hrdata;
    endtask

    task automatic next_pix(output bl1_pkg::bl1_pix_t p);
        do @(negedge hclk); while (pix_valid !== 1'h1 || pix_ready !== 1'h1);
        p = pix;
        @(posedge hclk);
    endtask

    task automatic grab(output logic [15:0] va, output logic [31:0] pa,
                        output bl1_pkg::bl1_pix_t p);
        do @(negedge hclk); while (vram_rd !== 1'h1);
        va = vram_addr;
        do @(negedge hclk); while (pat_req !== 1'h1 || pat_ack !== 1'h1);
        pa = pat_addr;
        next_pix(p);
    endtask

    task automatic t_regs;
        logic [31:0] r;
        for (int i = 0; i < 7; i++) begin
            ahb(1'h0, RA[i], 32'h0, r);
            chk("reset", r, 32'h0);
            ahb(1'h1, RA[i], 32'hFFFF_FF50 + i, r);
            ahb(1'h0, RA[i], 32'h0, r);
            chk("readback", r, (i < 6) ? 32'h50 + i : 32'h0);
        end
        chk("okay", hresp, 1'h0);
        $display("test regs done");
    endtask

    task automatic t_pal;
        logic [31:0] r;
        for (int i = 0; i < 512; i++) ahb(1'h1, 32'h9000 + 4 * i, {16'h0, palv(i)}, r);
        ahb(1'h0, 32'h97FC, 32'h0, r);
        chk("palette", r, {16'h0, palv(511)});
        $display("test palette done");
    endtask

    task automatic t_clear;
        bl1_pkg::bl1_pix_t p;
        logic [31:0]       r;
        for (int k = 0; k < 2; k++) begin
            ent <= k ? 16'h0000 : 16'h5003;
            ahb(1'h1, 32'h8048, k ? 32'h01 : 32'h00, r);
            next_pix(p);
            next_pix(p);
            chk("clear", p.transparent, 1'h1);
        end
        $display("test clear done");
    endtask

    task automatic t_char;
        bl1_pkg::bl1_pix_t p;
        logic [31:0]       r, pa;
        logic [15:0]       va, pv;
        logic [8:0]        lx, ly, pi;
        logic [7:0]        c;
        int                w, s, b, bo, idx;
        ent <= 16'h5003;
        for (int k = 0; k < 6; k++) begin
            ahb(1'h1, 32'h8040, {24'h0, SH[k]}, r);
            ahb(1'h1, 32'h8044, {24'h0, SV[k]}, r);
            ahb(1'h1, 32'h8048, {24'h0, C1[k]}, r);
            ahb(1'h1, 32'h804C, {24'h0, C2[k]}, r);
            ahb(1'h1, 32'h8070, 32'h01, r);
            ahb(1'h1, 32'h8074, 32'h00, r);
            next_pix(p);
            for (int j = 0; j < 3; j++) begin
                grab(va, pa, p);
                w  = C1[k][4] ? 16 : 8;
                s  = C1[k][4] ? 4 : 3;
                b  = 2 * (C1[k][7:6] + 1);
                lx = (p.col + {C2[k][2], SH[k]}) & (C1[k][1] ? 9'h1FF : 9'h0FF);
                ly = (p.row + {C2[k][3], SV[k]}) & (C1[k][2] ? 9'h1FF : 9'h0FF);
                idx = ((s == 3) ? (ly[8] | lx[8]) << 10 : (ly[8] << 9) | (lx[8] << 8))
                    | ((ly[7:0] >> s) << (8 - s)) | (lx[7:0] >> s);
                chk("vram", va, 16'h3000 | (idx << 1));
                bo = ((ly % w) * w + lx % w) * b;
                chk("paddr", pa, 32'h2000 + 3 * w * w * b / 8 + bo / 8);
                c = 8'(pw >> (bo % 8)) & 8'((1 << b) - 1);
                case (C1[k][7:6])
                    2'h0: pi = {C2[k][4], 4'h5, 2'h0, c[1:0]};
                    2'h1: pi = {C2[k][4], 4'h5, c[3:0]};
                    2'h2: pi = {C2[k][4], 2'h1, c[5:0]};
                    default: pi = {C2[k][4], c};
                endcase
                pv = palv(pi);
                chk("pixel", p[18:0], {1'h0, pv, C2[k][1:0]});
            end
        end
        $display("test char done");
    endtask

    task automatic t_direct;
        bl1_pkg::bl1_pix_t p;
        logic [31:0]       r, pa;
        logic [15:0]       va, pv;
        logic [7:0]        lx, ly;
        slow <= 1'h1;
        for (int k = 0; k < 3; k++) begin
            pw <= PW[k];
            // linear ignores size bit; depth 3 sets 8-bit pixels, high colour sets 16
            ahb(1'h1, 32'h8048, {24'h0, CF[k]}, r);
            next_pix(p);
            pix_ready <= 1'h0;
            repeat (12) @(posedge hclk);
            pix_ready <= 1'h1;
            grab(va, pa, p);
            lx = p.col + SH[5];
            ly = p.row + SV[5];
            chk("lvram", va, 16'h3000 | (ly << 1));
            chk("lpaddr", pa, 32'h2000 + (768 + lx) * (CF[k][5] ? 2 : 1));
            pv = palv(PW[k][7:0]);
            chk("colour", {p.transparent, p.rgb}, CF[k][5] ? PW[k] : {1'h0, pv[14:0]});
        end
        slow <= 1'h0;
        $display("test direct done");
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim;
        end
    end

    initial begin
        hclk = 1'h0;
        hresetn = 1'h0;
        hsel = 1'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        pix_ready = 1'h1;
        ent = 16'h5003;
        pw = 16'h6C39;
        slow = 1'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        t_regs;
        t_pal;
        t_clear;
        t_char;
        t_direct;
        end_sim;
    end
endmodule

bind bl1_render bl1_render_sva i_bl1_render_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .vram_addr, .vram_rd, .vram_rdata, .pat_req, .pat_addr, .pat_ack,
    .pix_valid, .pix_ready, .pix);

// [testbench/bl1_render_sva.sv]
// Port checker for the first background layer renderer.
// Assumes one clock domain; bound to bl1_render from the bench top file.
`timescale 1ns/1ps
module bl1_render_sva (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic [15:0]       vram_addr,
    input wire logic              vram_rd,
    input wire logic [15:0]       vram_rdata,
    input wire logic              pat_req,
    input wire logic [31:0]       pat_addr,
    input wire logic              pat_ack,
    input wire logic              pix_valid,
    input wire logic              pix_ready,
    input wire bl1_pkg::bl1_pix_t pix
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       seen;
    logic [7:0] exp_col;
    logic [7:0] exp_row;
    wire        take = hsel && hready && htrans[1];
    wire        acc  = pix_valid && pix_ready;

    // Scan position expected at the next accepted pixel
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen    <= 1'h0;
            exp_col <= 8'h00;
            exp_row <= 8'h00;
        end else if (acc) begin
            seen    <= 1'h1;
            exp_col <= pix.col + 8'h01;
            exp_row <= (pix.col != 8'hFF) ? pix.row : (pix.row == 8'hEF) ? 8'h00 : pix.row + 8'h01;
        end
    end

    sequence zero_name;
        vram_rd ##1 (vram_rdata == 16'h0000);
    endsequence
    sequence fetch_done;
        pat_req && pat_ack;
    endsequence

    chk_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_pix_hold: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix))
        else $error("pixel changed before accept");
    chk_pat_hold: assert property (pat_req && !pat_ack |=> pat_req && $stable(pat_addr))
        else $error("pattern request dropped");
    chk_vram_range: assert property (vram_rd |-> vram_addr[15:12] == 4'h3 && !vram_addr[0])
        else $error("name read outside video RAM");
    chk_name_pix: assert property (vram_rd |-> ##[2:12] pix_valid)
        else $error("no pixel after name read");
    chk_fetch_pix: assert property (fetch_done |=> ##[0:2] pix_valid)
        else $error("no pixel after pattern fetch");
    chk_zero_clear: assert property (zero_name |=> !pat_req ##[0:3] (pix_valid && pix.transparent))
        else $error("zero name entry not transparent");
    chk_scan_order: assert property (acc && seen |-> pix.col == exp_col && pix.row == exp_row)
        else $error("pixel scan order broken");
endmodule
